// ### ecfc_defs.svh
// Purpose: Named constants for the extended attribute feature commands.
// Assumes: Four-bit feature command codes arrive in the low nibble.
// Notes: Definitions only; included by every file that needs them.
`ifndef ECFC_DEFS_SVH
`define ECFC_DEFS_SVH

// Feature command codes
`define ECFC_OP_READ_DATA 4'h3
`define ECFC_OP_LOAD_MASK 4'h5
`define ECFC_OP_FID_CARE 4'hd
`define ECFC_OP_FID_PAT 4'h5
`define ECFC_OP_WR_ALT 4'ha
`define ECFC_OP_READ_MULT 4'hb
`define ECFC_OP_WR_MASK 4'hc
`define ECFC_OP_READ_STAT 4'hd

// Fixed reply bytes and reset values
`define ECFC_STATUS_BYTE 8'h20
`define ECFC_FID_DEFAULT 8'h5a
`define ECFC_MASK_RST 8'h00
`define ECFC_BYTE_ZERO 8'h00

`endif

// ### ecfc_pkg.sv
// Purpose: Types shared by the extended attribute command interpreter.
// Assumes: Nothing beyond the constants header.
// Notes: States are one-hot with codes written out.
package ecfc_pkg;

  // Terminal operating mode as given by the surrounding device
  typedef enum logic [1:0] {
    MODE_DISPLAY = 2'h0,
    MODE_PRINTER = 2'h1,
    MODE_DFT = 2'h2
  } ecfc_mode_e;

  // Interpreter states
  typedef enum logic [8:0] {
    ST_IDLE = 9'h001,
    ST_MASK_DATA = 9'h002,
    ST_WA_DBUF = 9'h004,
    ST_WA_EAB = 9'h008,
    ST_WUM = 9'h010,
    ST_EAB_RD = 9'h020,
    ST_EAB_MRG = 9'h040,
    ST_RD_REQ = 9'h080,
    ST_RD_CAP = 9'h100
  } ecfc_state_e;

endpackage

// ### ecfc_top.sv
// Purpose: Decode and run the extended attribute feature commands.
// Assumes: Link receiver hands over one frame per rx_valid_i pulse;
//   buffer reads return data the cycle after the read strobe.
// Notes: The base logic owns the address counter; this block only
//   asks it to step. Frames that arrive during a buffer access drop.
`include "ecfc_defs.svh"

// Contract
// - Read Feature ID (01X1) replies with the fixed feature identification byte; code 0101 runs the mask load instead.
// - Read Multiple: gate bit set gives turnaround only, else base Read Multiple.
// - Write Alternate writes bytes alternately, data buffer first, then attribute.
// - Attribute bytes of Write Alternate are masked; step unless inhibit bit set.
// - Load Extended Attribute Mask stores the next data byte as attribute mask.
// - Write Under Mask: new = (old AND NOT mask) OR data.
// - After each Write Under Mask write, step address unless inhibit bit set.
// - Read Status replies with the fixed byte 20 hex.
// - Feature commands are honoured only in character terminal display mode.
// - Read Data returns buffer data, then steps unless inhibit bit set.
module ecfc_top #(
  parameter logic [7:0] FEATURE_ID = `ECFC_FID_DEFAULT // Arbitrary value
) (
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic srst_i,
  // Received frames from the link
  input wire logic rx_valid_i,
  input wire logic rx_cmd_i,
  input wire logic [7:0] rx_data_i,
  // Device state bits owned elsewhere
  input wire ecfc_pkg::ecfc_mode_e mode_i,
  input wire logic rm_gate_i,
  input wire logic inhibit_step_i,
  // Buffer storage access
  input wire logic [7:0] buf_rdata_i,
  input wire logic [7:0] eab_rdata_i,
  output logic buf_rd_o,
  output logic dbuf_wr_o,
  output logic [7:0] dbuf_wdata_o,
  output logic eab_rd_o,
  output logic eab_wr_o,
  output logic [7:0] eab_wdata_o,
  output logic addr_step_o,
  // Replies toward the link transmitter
  output logic reply_valid_o,
  output logic reply_tt_o,
  output logic [7:0] reply_data_o,
  // Hand-off and diagnostics
  output logic base_rm_o,
  output logic cmd_ignored_o,
  output logic [7:0] attr_mask_o
);

  ecfc_pkg::ecfc_state_e state_r;
  ecfc_pkg::ecfc_state_e state_nxt;
  logic [7:0] mask_r;
  logic [7:0] hold_r;
  logic ret_alt_r;

  // Frame classification
  wire logic [3:0] op = rx_data_i[3:0];
  wire logic st_waits = (state_r == ecfc_pkg::ST_IDLE) ||
                        (state_r == ecfc_pkg::ST_MASK_DATA) ||
                        (state_r == ecfc_pkg::ST_WA_DBUF) ||
                        (state_r == ecfc_pkg::ST_WA_EAB) ||
                        (state_r == ecfc_pkg::ST_WUM);
  wire logic cmd_frame = rx_valid_i && rx_cmd_i && st_waits;
  wire logic data_frame = rx_valid_i && !rx_cmd_i;
  wire logic mode_ok = (mode_i == ecfc_pkg::MODE_DISPLAY);
  wire logic cmd_take = cmd_frame && mode_ok;

  // Opcode decode; 0101 is taken by the mask load before feature ID
  wire logic is_rdata = (op == `ECFC_OP_READ_DATA);
  wire logic is_lmask = (op == `ECFC_OP_LOAD_MASK);
  wire logic is_fid = ((op & `ECFC_OP_FID_CARE) == `ECFC_OP_FID_PAT) &&
                      !is_lmask;
  wire logic is_walt = (op == `ECFC_OP_WR_ALT);
  wire logic is_rmult = (op == `ECFC_OP_READ_MULT);
  wire logic is_wum = (op == `ECFC_OP_WR_MASK);
  wire logic is_rstat = (op == `ECFC_OP_READ_STAT);
  wire logic is_known = is_rdata || is_lmask || is_fid || is_walt ||
                        is_rmult || is_wum || is_rstat;

  // Masked merge of a held data byte into the old attribute byte
  wire logic [7:0] merged = (eab_rdata_i & ~mask_r) | hold_r;
  wire logic step_ok = !inhibit_step_i; // Inhibit bit low allows stepping

  // Next state: a command frame restarts the decoder unless a buffer access is under way
  always_comb begin
    state_nxt = state_r;
    if (cmd_take) begin
      if (is_lmask) begin
        state_nxt = ecfc_pkg::ST_MASK_DATA;
      end else if (is_walt) begin
        state_nxt = ecfc_pkg::ST_WA_DBUF;
      end else if (is_wum) begin
        state_nxt = ecfc_pkg::ST_WUM;
      end else if (is_rdata) begin
        state_nxt = ecfc_pkg::ST_RD_REQ;
      end else begin
        state_nxt = ecfc_pkg::ST_IDLE;
      end
    end else if (cmd_frame) begin
      state_nxt = ecfc_pkg::ST_IDLE; // Wrong mode drops the command
    end else begin
      case (state_r)
        ecfc_pkg::ST_IDLE: begin
          state_nxt = ecfc_pkg::ST_IDLE;
        end
        ecfc_pkg::ST_MASK_DATA: begin
          if (data_frame) begin
            state_nxt = ecfc_pkg::ST_IDLE;
          end
        end
        ecfc_pkg::ST_WA_DBUF: begin
          if (data_frame) begin
            state_nxt = ecfc_pkg::ST_WA_EAB;
          end
        end
        ecfc_pkg::ST_WA_EAB: begin
          if (data_frame) begin
            state_nxt = ecfc_pkg::ST_EAB_RD;
          end
        end
        ecfc_pkg::ST_WUM: begin
          if (data_frame) begin
            state_nxt = ecfc_pkg::ST_EAB_RD;
          end
        end
        ecfc_pkg::ST_EAB_RD: begin
          state_nxt = ecfc_pkg::ST_EAB_MRG;
        end
        ecfc_pkg::ST_EAB_MRG: begin
          state_nxt = ret_alt_r ? ecfc_pkg::ST_WA_DBUF : ecfc_pkg::ST_WUM;
        end
        ecfc_pkg::ST_RD_REQ: begin
          state_nxt = ecfc_pkg::ST_RD_CAP;
        end
        ecfc_pkg::ST_RD_CAP: begin
          state_nxt = ecfc_pkg::ST_IDLE;
        end
        default: begin
          state_nxt = ecfc_pkg::ST_IDLE;
        end
      endcase
    end
  end

  // Reply strobes; write commands answer with turnaround on decode
  wire logic rep_tt_cmd = cmd_take && (is_lmask || is_walt || is_wum ||
                          (is_rmult && rm_gate_i));
  wire logic rep_byte_cmd = cmd_take && (is_fid || is_rstat);
  wire logic rep_rd = (state_r == ecfc_pkg::ST_RD_CAP);
  wire logic [7:0] rep_byte = is_fid ? FEATURE_ID :
                              `ECFC_STATUS_BYTE;

  // Buffer access strobes
  wire logic wa_dbuf_wr = (state_r == ecfc_pkg::ST_WA_DBUF) && data_frame &&
                          !cmd_frame;
  wire logic eab_byte = ((state_r == ecfc_pkg::ST_WA_EAB) ||
                         (state_r == ecfc_pkg::ST_WUM)) && data_frame &&
                        !cmd_frame;
  wire logic mrg_now = (state_r == ecfc_pkg::ST_EAB_MRG);
  wire logic mask_ld = (state_r == ecfc_pkg::ST_MASK_DATA) && data_frame &&
                       !cmd_frame;

  // State and working registers
  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      state_r <= ecfc_pkg::ST_IDLE;
      mask_r <= `ECFC_MASK_RST;
      hold_r <= `ECFC_BYTE_ZERO;
      ret_alt_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      if (mask_ld) begin
        mask_r <= rx_data_i;
      end
      if (eab_byte) begin
        hold_r <= rx_data_i;
        ret_alt_r <= (state_r == ecfc_pkg::ST_WA_EAB);
      end
    end
  end

  // Buffer side outputs, all registered; strobes pulse, write data holds
  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      buf_rd_o <= 1'b0;
      dbuf_wr_o <= 1'b0;
      dbuf_wdata_o <= `ECFC_BYTE_ZERO;
      eab_rd_o <= 1'b0;
      eab_wr_o <= 1'b0;
      eab_wdata_o <= `ECFC_BYTE_ZERO;
      addr_step_o <= 1'b0;
    end else begin
      buf_rd_o <= cmd_take && is_rdata;
      dbuf_wr_o <= wa_dbuf_wr;
      if (wa_dbuf_wr) begin
        dbuf_wdata_o <= rx_data_i;
      end
      eab_rd_o <= eab_byte; // Old attribute needed for the merge
      eab_wr_o <= mrg_now;
      if (mrg_now) begin
        eab_wdata_o <= merged;
      end
      // Same address serves data and attribute; step after attribute
      addr_step_o <= (mrg_now || rep_rd) && step_ok;
    end
  end

  // Link side outputs
  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      reply_valid_o <= 1'b0;
      reply_tt_o <= 1'b0;
      reply_data_o <= `ECFC_BYTE_ZERO;
      base_rm_o <= 1'b0;
      cmd_ignored_o <= 1'b0;
    end else begin
      reply_valid_o <= rep_tt_cmd || rep_byte_cmd || rep_rd;
      reply_tt_o <= rep_tt_cmd;
      if (rep_byte_cmd) begin
        reply_data_o <= rep_byte;
      end else if (rep_rd) begin
        reply_data_o <= buf_rdata_i;
      end else if (rep_tt_cmd) begin
        reply_data_o <= `ECFC_BYTE_ZERO;
      end
      base_rm_o <= cmd_take && is_rmult && !rm_gate_i;
      cmd_ignored_o <= cmd_frame && (!mode_ok || !is_known);
    end
  end

  // Mask visible to the base Clear logic
  assign attr_mask_o = mask_r;

endmodule

// ### ecfc_chk_assertions.sv
// Purpose: Port-level checks for the feature command interpreter.
// Assumes: Commands are offered only while the interpreter is idle.
// Notes: Bound onto every ecfc_top instance.
module ecfc_chk #(
  parameter logic [7:0] FEATURE_ID = 8'h00
) (
  input wire logic clk_sys_i, srst_i, rx_valid_i, rx_cmd_i,
  input wire logic [7:0] rx_data_i, buf_rdata_i, eab_rdata_i,
  input wire ecfc_pkg::ecfc_mode_e mode_i,
  input wire logic rm_gate_i, inhibit_step_i, buf_rd_o, eab_rd_o,
  input wire logic eab_wr_o, addr_step_o, reply_valid_o, reply_tt_o,
  input wire logic base_rm_o, cmd_ignored_o,
  input wire logic [7:0] eab_wdata_o, reply_data_o, attr_mask_o
);
  // Command frame taken as a feature command, and its code
  wire logic cmd_ok;
  wire logic [3:0] op;
  assign cmd_ok = rx_valid_i && rx_cmd_i && mode_i == ecfc_pkg::MODE_DISPLAY;
  assign op = rx_data_i[3:0];
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (srst_i);
  fid_reply_a: assert property (
    cmd_ok && op == 4'h7 |=> reply_valid_o && !reply_tt_o
    && reply_data_o == FEATURE_ID) else $error("feature id reply wrong");
  rm_gate_a: assert property (
    cmd_ok && op == 4'hb |=> ($past(rm_gate_i) ? reply_valid_o
    && reply_tt_o && !base_rm_o : base_rm_o && !reply_valid_o))
    else $error("read multiple gating wrong");
  status_reply_a: assert property (
    cmd_ok && op == 4'hd |=> reply_valid_o && reply_data_o == 8'h20)
    else $error("status reply wrong");
  mode_block_a: assert property (
    rx_valid_i && rx_cmd_i && mode_i != ecfc_pkg::MODE_DISPLAY
    |=> cmd_ignored_o && !reply_valid_o && !base_rm_o)
    else $error("command honoured outside display mode");
  // Bits left by the mask must survive the merge
  merge_keep_a: assert property (
    eab_rd_o |-> ##2 eab_wr_o && ($past(eab_rdata_i) & ~attr_mask_o
    & ~eab_wdata_o) == 8'h00) else $error("masked merge lost bits");
  attr_step_a: assert property (
    eab_rd_o |-> ##2 addr_step_o == !$past(inhibit_step_i))
    else $error("attribute write step wrong");
  read_data_a: assert property (
    cmd_ok && op == 4'h3 |=> buf_rd_o ##2 reply_valid_o
    && reply_data_o == $past(buf_rdata_i)
    && addr_step_o == !$past(inhibit_step_i)) else $error("read data wrong");
  mask_load_a: assert property (
    !$stable(attr_mask_o) && !$past(srst_i) |-> $past(rx_valid_i)
    && !$past(rx_cmd_i) && attr_mask_o == $past(rx_data_i))
    else $error("mask changed without a data frame");
  // Main scenarios reached
  cover property (eab_wr_o && addr_step_o);
  cover property (reply_valid_o && reply_tt_o);
  cover property (cmd_ignored_o);
  cover property (reply_valid_o && !reply_tt_o && !addr_step_o);
endmodule

bind ecfc_top ecfc_chk #(.FEATURE_ID(FEATURE_ID)) ecfc_chk_inst (.*);

// ### ecfc_cu_model.sv
// Purpose: Control unit model that feeds frames to the interpreter.
// Assumes: Caller keeps the spacing the interpreter needs.
// Notes: Payload is inverted once a frame is gone, so stale data
//   never passes for a live frame.
module ecfc_cu_model (
  input wire logic clk_sys_i,
  output logic rx_valid_o,
  output logic rx_cmd_o,
  output logic [7:0] rx_data_o
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    rx_valid_o = 1'b0;
    rx_cmd_o = 1'b0;
    rx_data_o = 8'h00;
  end
  // One frame held for exactly one cycle
  task automatic send(input logic cmd, input logic [7:0] data);
    @(posedge clk_sys_i);
    #1;
    rx_valid_o = 1'b1;
    rx_cmd_o = cmd;
    rx_data_o = data;
    @(posedge clk_sys_i);
    #1;
    rx_valid_o = 1'b0;
    rx_data_o = ~data;
  endtask
endmodule

// ### tb_extended_attr_feature_cmds.sv
// Purpose: Self-checking bench for the feature command interpreter.
// Assumes: Buffer storage answers one cycle after the read strobe.
// Notes: Scenarios wait the fixed latencies of the interpreter.
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin mismatches++; \
  $display("BAD t=%0t got=%h exp=%h", $time, g, e); end end
module tb_extended_attr_feature_cmds;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [7:0] FID = 8'h6e; // Arbitrary value
  logic clk = 1'b0, srst = 1'b1, gate = 1'b0, inh = 1'b0;
  logic rv, rc, buf_rd, dbuf_wr, eab_rd, eab_wr, step, rvalid, rtt;
  logic base_rm, ign;
  logic [7:0] rd, dbuf_wdata, eab_wdata, rdata, mask;
  logic [7:0] buf_rdata = 8'h00, eab_rdata = 8'h00;
  ecfc_pkg::ecfc_mode_e mode = ecfc_pkg::MODE_DISPLAY;
  int mismatches = 0, compares = 0;
  always #4 clk = ~clk;
  // Storage answers after a strobe, toggling junk otherwise
  always @(posedge clk) begin
    buf_rdata <= buf_rd ? 8'ha5 : ~buf_rdata;
    eab_rdata <= eab_rd ? 8'h3c : ~eab_rdata;
  end
  ecfc_cu_model ecfc_cu_model_inst (.clk_sys_i(clk), .rx_valid_o(rv),
    .rx_cmd_o(rc), .rx_data_o(rd));
  ecfc_top #(.FEATURE_ID(FID)) ecfc_top_inst (.clk_sys_i(clk),
    .srst_i(srst), .rx_valid_i(rv), .rx_cmd_i(rc), .rx_data_i(rd),
    .mode_i(mode), .rm_gate_i(gate), .inhibit_step_i(inh),
    .buf_rdata_i(buf_rdata), .eab_rdata_i(eab_rdata), .buf_rd_o(buf_rd),
    .dbuf_wr_o(dbuf_wr), .dbuf_wdata_o(dbuf_wdata), .eab_rd_o(eab_rd),
    .eab_wr_o(eab_wr), .eab_wdata_o(eab_wdata), .addr_step_o(step),
    .reply_valid_o(rvalid), .reply_tt_o(rtt), .reply_data_o(rdata),
    .base_rm_o(base_rm), .cmd_ignored_o(ign), .attr_mask_o(mask));
  task automatic wt(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic snd(input logic c, input logic [7:0] d);
    ecfc_cu_model_inst.send(c, d);
  endtask
  task automatic t_ids();
    snd(1'b1, 8'h07);
    `CHK({rvalid, rtt, rdata}, {2'b10, FID})
    snd(1'b1, 8'h0d);
    `CHK({rvalid, rtt, rdata}, {2'b10, 8'h20})
  endtask
  task automatic t_rm();
    gate = 1'b1;
    snd(1'b1, 8'h0b);
    `CHK({rvalid, rtt, base_rm}, 3'b110)
    gate = 1'b0;
    snd(1'b1, 8'h0b);
    `CHK({rvalid, base_rm}, 2'b01)
  endtask
  // Mask f0 clears high bits of old 3c; a data one always sets
  task automatic t_wum();
    snd(1'b1, 8'h05);
    snd(1'b0, 8'hf0);
    `CHK(mask, 8'hf0)
    snd(1'b1, 8'h0c);
    snd(1'b0, 8'h01);
    wt(2);
    `CHK({eab_wr, step, eab_wdata}, {2'b11, 8'h0d})
    inh = 1'b1;
    snd(1'b0, 8'h80);
    wt(2);
    `CHK({eab_wr, step, eab_wdata}, {2'b10, 8'h8c})
    inh = 1'b0;
  endtask
  task automatic t_walt();
    snd(1'b1, 8'h0a);
    snd(1'b0, 8'h41);
    `CHK({dbuf_wr, eab_rd, dbuf_wdata}, {2'b10, 8'h41})
    snd(1'b0, 8'h02);
    `CHK({dbuf_wr, eab_rd}, 2'b01)
    wt(2);
    `CHK({eab_wr, step, eab_wdata}, {2'b11, 8'h0e})
    snd(1'b0, 8'h77);
    `CHK({dbuf_wr, dbuf_wdata}, {1'b1, 8'h77})
  endtask
  task automatic t_rd();
    snd(1'b1, 8'h03);
    `CHK(buf_rd, 1'b1)
    wt(2);
    `CHK({rvalid, step, rdata}, {2'b11, 8'ha5})
    // Inhibit bit set: data still returned, address must hold
    inh = 1'b1;
    snd(1'b1, 8'h03);
    wt(2);
    `CHK({rvalid, step, rdata}, {2'b10, 8'ha5})
    inh = 1'b0;
  endtask
  task automatic t_mode();
    mode = ecfc_pkg::MODE_PRINTER;
    snd(1'b1, 8'h07);
    `CHK({ign, rvalid}, 2'b10)
    mode = ecfc_pkg::MODE_DFT;
    snd(1'b1, 8'h0c);
    `CHK({ign, rvalid}, 2'b10)
    mode = ecfc_pkg::MODE_DISPLAY;
    // A code outside the feature set is dropped even in display mode
    snd(1'b1, 8'h01);
    `CHK({ign, rvalid}, 2'b10)
  endtask
  task automatic conclude();
    $display("compares=%0d mismatches=%0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  initial begin
    wt(6);
    srst = 1'b0;
    t_ids();
    t_rm();
    t_wum();
    t_walt();
    t_rd();
    t_mode();
    wt(4);
    conclude();
  end
endmodule
